// [src/uopc_top.sv]
// USB OTG line, VBUS and power control block with APB register access.
// Summary of operation
// - Control bits 7 and 6 enable the D+ and D- pull-ups.
// - Control bits 5 and 4 enable the D+ and D- pull-downs.
// - Bit 2 high gives software the pull enables, low gives hardware.
// - Control bit 3 drives the VBUS power-on output.
// - Control bit 1 enables VBUS charging through a pull-up.
// - Control bit 0 enables VBUS discharging through a pull-down.
// - Bits 31 to 8 read zero; implemented bits reset to zero.
// - Power bit 7 shows activity seen but its interrupt not yet raised.
// - Power bit 4 blocks sleep on activity or pending notice.
// - Power bit 3 shows busy while on or not yet ready.
// - Power bit 1 gates the USB clock and idles the transceiver.
// - Power bit 0 off holds line and VBUS outputs inactive and releases pins.
// - Error summary flag is read-only; other seven flags are clearable.
// - Hardware sets flags; writing one clears a flag.
// - Flag bit 0 marks bus reset in device or detach in host mode.
// - Clearing token-complete advances the status FIFO.
// - Error summary sets only from enabled error conditions.
`timescale 1ns/100ps
module uopc_top
  import uopc_pkg::*;
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware controller inputs.
  input wire logic [3:0] hw_pull_enable,
  input wire logic bus_activity,
  input wire logic activity_irq_raised,
  input wire logic host_mode,
  input wire logic [7:0] flag_events,
  input wire logic [7:0] error_conditions,
  input wire logic [7:0] error_interrupt_enable_register,
  // Line and power outputs.
  output logic dplus_pullup_enable,
  output logic dminus_pullup_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  output logic vbus_power_on,
  output logic vbus_charge_enable,
  output logic vbus_discharge_enable,
  output logic usb_clock_gate,
  output logic xcvr_low_power,
  output logic pins_owned,
  output logic sleep_block,
  output logic status_fifo_advance
);
  logic [7:0] otgcon_r;
  logic [7:0] pwrc_r;
  logic activity_pending_r;
  logic [7:0] flags;
  logic [7:0] flag_clr;
  logic [7:0] flag_set;
  logic [7:0] pull_sel;
  logic [31:0] rdata_nxt;
  logic module_busy;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign addr_ok = (paddr[31:4] == 28'h0000000) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_acc = psel && penable && pwrite && addr_ok;
  assign rd_acc = psel && !penable && !pwrite;

  // Control register; all bits software-writable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otgcon_r <= UOPC_RESET_VAL;
    end else if (wr_acc && paddr[3:0] == UOPC_ADDR_OTGCON) begin
      otgcon_r <= pwdata[7:0];
    end
  end

  // Power register; the read-only busy and pending bits are never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrc_r <= UOPC_RESET_VAL;
    end else if (wr_acc && paddr[3:0] == UOPC_ADDR_PWRC) begin
      pwrc_r <= pwdata[7:0] & UOPC_PWRC_WMASK;
    end
  end

  // Activity pending: set on activity while switched on, cleared once the interrupt has been raised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activity_pending_r <= 1'b0;
    end else if (activity_irq_raised) begin
      activity_pending_r <= 1'b0;
    end else if (bus_activity && pwrc_r[UOPC_OPEN_BIT]) begin
      activity_pending_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy tracker.
  uopc_shutdown #(.CYCLES(UOPC_SHUTDOWN_CYC)) u_shutdown (
    .pclk(pclk),
    .presetn(presetn),
    .enable_i(pwrc_r[UOPC_OPEN_BIT]),
    .busy_r(module_busy)
  );

  // Flag set and clear terms; the error summary takes only enabled errors.
  always_comb begin
    flag_set = flag_events & UOPC_IRQF_CMASK;
    flag_set[UOPC_ERRF_BIT] = |(error_conditions & error_interrupt_enable_register);
    flag_clr = (wr_acc && paddr[3:0] == UOPC_ADDR_IRQF) ?
      (pwdata[7:0] & UOPC_IRQF_CMASK) : 8'h00;
    flag_clr[UOPC_ERRF_BIT] = !flag_set[UOPC_ERRF_BIT];
  end

  // Eight flag bits; the summary bit simply mirrors live enabled errors.
  for (genvar i = 0; i < UOPC_REG_W; i++) begin : g_flag
    uopc_flag u_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set_i(flag_set[i]),
      .clr_i(flag_clr[i]),
      .flag_r(flags[i])
    );
  end

  // Token-complete clear pulses the FIFO advance for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_fifo_advance <= 1'b0;
    end else begin
      status_fifo_advance <= flag_clr[UOPC_TOKF_BIT] && flags[UOPC_TOKF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: captured in setup so it is stable through the access phase.
  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (paddr[3:0])
      UOPC_ADDR_OTGCON: rdata_nxt[7:0] = otgcon_r;
      UOPC_ADDR_PWRC: begin
        rdata_nxt[7:0] = pwrc_r;
        rdata_nxt[UOPC_ACTP_BIT] = activity_pending_r;
        rdata_nxt[UOPC_BUSY_BIT] = module_busy;
      end
      UOPC_ADDR_IRQF: rdata_nxt[7:0] = flags;
      UOPC_ADDR_HWPULL: rdata_nxt[3:0] = hw_pull_enable;
      default: rdata_nxt = 32'h00000000;
    endcase
    // The low nibble alone would alias an unmapped word onto a register.
    if (!addr_ok) begin
      rdata_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_acc) begin
      prdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull enables: software or hardware ownership, then held off when powered down.
  always_comb begin
    if (otgcon_r[UOPC_SWOWN_BIT]) begin
      pull_sel[7:4] = otgcon_r[7:4];
    end else begin
      pull_sel[7:4] = hw_pull_enable;
    end
    pull_sel[3:0] = otgcon_r[3:0];
    if (!pwrc_r[UOPC_OPEN_BIT]) begin
      pull_sel = 8'h00;
    end
  end

  // Output flops keep the pin controls glitch-free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dplus_pullup_enable <= 1'b0;
      dminus_pullup_enable <= 1'b0;
      dplus_pulldown_enable <= 1'b0;
      dminus_pulldown_enable <= 1'b0;
      vbus_power_on <= 1'b0;
      vbus_charge_enable <= 1'b0;
      vbus_discharge_enable <= 1'b0;
    end else begin
      dplus_pullup_enable <= pull_sel[UOPC_DPPU_BIT];
      dminus_pullup_enable <= pull_sel[UOPC_DMPU_BIT];
      dplus_pulldown_enable <= pull_sel[UOPC_DPPD_BIT];
      dminus_pulldown_enable <= pull_sel[UOPC_DMPD_BIT];
      vbus_power_on <= pull_sel[UOPC_VBON_BIT];
      vbus_charge_enable <= pull_sel[UOPC_VBCHG_BIT];
      vbus_discharge_enable <= pull_sel[UOPC_VBDIS_BIT];
    end
  end

  // Suspend, pin ownership and sleep guard.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_clock_gate <= 1'b0;
      xcvr_low_power <= 1'b0;
      pins_owned <= 1'b0;
      sleep_block <= 1'b0;
    end else begin
      usb_clock_gate <= pwrc_r[UOPC_SUSP_BIT] || !pwrc_r[UOPC_OPEN_BIT];
      xcvr_low_power <= pwrc_r[UOPC_SUSP_BIT] || !pwrc_r[UOPC_OPEN_BIT];
      pins_owned <= pwrc_r[UOPC_OPEN_BIT];
      sleep_block <= pwrc_r[UOPC_SLPG_BIT] &&
        (bus_activity || activity_pending_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_pullup_follow: assert property (@(posedge pclk) disable iff (!presetn)
    otgcon_r[UOPC_SWOWN_BIT] && pwrc_r[UOPC_OPEN_BIT] |=> dplus_pullup_enable ==
      $past(otgcon_r[UOPC_DPPU_BIT]))
    else $error("D+ pull-up does not follow control.");
  chk_pulldown_follow: assert property (@(posedge pclk) disable iff (!presetn)
    otgcon_r[UOPC_SWOWN_BIT] && pwrc_r[UOPC_OPEN_BIT] |=> dminus_pulldown_enable ==
      $past(otgcon_r[UOPC_DMPD_BIT]))
    else $error("D- pull-down does not follow control.");
  chk_hw_owner: assert property (@(posedge pclk) disable iff (!presetn)
    !otgcon_r[UOPC_SWOWN_BIT] && pwrc_r[UOPC_OPEN_BIT] |=> dminus_pullup_enable ==
      $past(hw_pull_enable[2]))
    else $error("Hardware pull ownership not honoured.");
  chk_vbus_on: assert property (@(posedge pclk) disable iff (!presetn)
    pwrc_r[UOPC_OPEN_BIT] && $past(pwrc_r[UOPC_OPEN_BIT]) |->
      vbus_power_on == $past(otgcon_r[UOPC_VBON_BIT]))
    else $error("VBUS power-on mismatch.");
  chk_off_inactive: assert property (@(posedge pclk) disable iff (!presetn)
    !pwrc_r[UOPC_OPEN_BIT] |=> !vbus_charge_enable && !vbus_discharge_enable && !pins_owned)
    else $error("Outputs active while switched off.");
  chk_suspend_gate: assert property (@(posedge pclk) disable iff (!presetn)
    pwrc_r[UOPC_SUSP_BIT] |=> usb_clock_gate && xcvr_low_power)
    else $error("Suspend did not gate clock.");
  chk_sleep_guard: assert property (@(posedge pclk) disable iff (!presetn)
    !pwrc_r[UOPC_SLPG_BIT] |=> !sleep_block)
    else $error("Sleep blocked with guard off.");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("Unimplemented bits read nonzero.");
  chk_fifo_advance: assert property (@(posedge pclk) disable iff (!presetn)
    flag_clr[UOPC_TOKF_BIT] && flags[UOPC_TOKF_BIT] |=> status_fifo_advance)
    else $error("FIFO not advanced on token clear.");
  chk_token_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    status_fifo_advance |-> !flags[UOPC_TOKF_BIT] || $past(flag_set[UOPC_TOKF_BIT]))
    else $error("FIFO advanced but token flag still set.");
  chk_error_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(error_conditions & error_interrupt_enable_register)) |=> !flags[UOPC_ERRF_BIT])
    else $error("Error summary set without enabled error.");

  cov_sw_owner: cover property (@(posedge pclk) disable iff (!presetn)
    otgcon_r[UOPC_SWOWN_BIT] ##1 dplus_pullup_enable);
  cov_suspend: cover property (@(posedge pclk) disable iff (!presetn) usb_clock_gate);
  cov_flag_clear: cover property (@(posedge pclk) disable iff (!presetn)
    status_fifo_advance);
endmodule

// [src/uopc_pkg.sv]
// Package with register map, field positions and reset values for the USB OTG power control block.
package uopc_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [3:0] UOPC_ADDR_OTGCON = 4'h0;
  localparam logic [3:0] UOPC_ADDR_PWRC = 4'h4;
  localparam logic [3:0] UOPC_ADDR_IRQF = 4'h8;
  localparam logic [3:0] UOPC_ADDR_HWPULL = 4'hC;
  // Implemented field width of the control, power and flag registers.
  localparam int UOPC_REG_W = 8;
  // Line and VBUS control field positions.
  localparam int UOPC_DPPU_BIT = 7;
  localparam int UOPC_DMPU_BIT = 6;
  localparam int UOPC_DPPD_BIT = 5;
  localparam int UOPC_DMPD_BIT = 4;
  localparam int UOPC_VBON_BIT = 3;
  localparam int UOPC_SWOWN_BIT = 2;
  localparam int UOPC_VBCHG_BIT = 1;
  localparam int UOPC_VBDIS_BIT = 0;
  // Power control field positions.
  localparam int UOPC_ACTP_BIT = 7;
  localparam int UOPC_SLPG_BIT = 4;
  localparam int UOPC_BUSY_BIT = 3;
  localparam int UOPC_SUSP_BIT = 1;
  localparam int UOPC_OPEN_BIT = 0;
  // Interrupt flag positions.
  localparam int UOPC_ERRF_BIT = 1;
  localparam int UOPC_TOKF_BIT = 3;
  // Writable masks and reset values.
  localparam logic [7:0] UOPC_PWRC_WMASK = 8'h13;
  localparam logic [7:0] UOPC_IRQF_CMASK = 8'hFD;
  localparam logic [7:0] UOPC_RESET_VAL = 8'h00;
  // Cycles the module stays busy after it is switched off.
  localparam int UOPC_SHUTDOWN_CYC = 8;
endpackage

// [src/uopc_flag.sv]
// One hardware-set, write-one-to-clear interrupt flag bit.
`timescale 1ns/100ps
module uopc_flag
  import uopc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear requests.
  input wire logic set_i,
  input wire logic clr_i,
  // Flag state.
  output logic flag_r
);
  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end
endmodule

// [src/uopc_shutdown.sv]
// Busy tracker that models the settle time after the module is switched off.
`timescale 1ns/100ps
module uopc_shutdown
  import uopc_pkg::*;
#(
  parameter int CYCLES = UOPC_SHUTDOWN_CYC
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Operation enable.
  input wire logic enable_i,
  // Busy indication.
  output logic busy_r
);
  logic [7:0] cnt_r;

  // Busy while on, then for CYCLES cycles after switch-off; re-enabling reloads the count at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
    end else if (enable_i) begin
      cnt_r <= 8'(CYCLES);
      busy_r <= 1'b1;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
      busy_r <= 1'b1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  chk_busy_after_off: assert property (@(posedge pclk) disable iff (!presetn)
    enable_i ##1 !enable_i |-> busy_r)
    else $error("Busy dropped right after switch-off.");
endmodule

// [test/uopc_peer.sv]
// Cable peer model that turns bench commands into controller events.
`timescale 1ns/100ps
module uopc_peer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench.
  input wire logic [7:0] ev_cmd,
  input wire logic act_cmd,
  input wire logic irq_cmd,
  // Event lines into the block.
  output logic [7:0] flag_events,
  output logic bus_activity,
  output logic activity_irq_raised
);
  // Events leave registered, so a one-cycle command gives a one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_events <= 8'h00;
      bus_activity <= 1'b0;
      activity_irq_raised <= 1'b0;
    end else begin
      flag_events <= ev_cmd;
      bus_activity <= act_cmd;
      activity_irq_raised <= irq_cmd;
    end
  end
endmodule

// [test/uopc_top_test.sv]
// Self-checking bench for the USB OTG power control block.
`timescale 1ns/100ps
module uopc_top_test
  import uopc_pkg::*;
;
  localparam logic [7:0] A_CON = {4'h0, UOPC_ADDR_OTGCON};
  localparam logic [7:0] A_PWR = {4'h0, UOPC_ADDR_PWRC};
  localparam logic [7:0] A_IRQ = {4'h0, UOPC_ADDR_IRQF};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] hw_pull;
  logic [7:0] ev_cmd, flag_ev, err_cond, err_en;
  logic act_cmd, irq_cmd, bus_act, irq_raised;
  logic dpu, dmu, dpd, dmd, vbon, vchg, vdis, clk_gate, xlp, pins, slp, fifo_adv;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_adv = 0;

  uopc_top uopc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_pull_enable(hw_pull), .bus_activity(bus_act),
    .activity_irq_raised(irq_raised), .host_mode(1'b0), .flag_events(flag_ev),
    .error_conditions(err_cond), .error_interrupt_enable_register(err_en),
    .dplus_pullup_enable(dpu), .dminus_pullup_enable(dmu), .dplus_pulldown_enable(dpd),
    .dminus_pulldown_enable(dmd), .vbus_power_on(vbon), .vbus_charge_enable(vchg),
    .vbus_discharge_enable(vdis), .usb_clock_gate(clk_gate), .xcvr_low_power(xlp),
    .pins_owned(pins), .sleep_block(slp), .status_fifo_advance(fifo_adv));
  uopc_peer uopc_peer_inst (.pclk(pclk), .presetn(presetn), .ev_cmd(ev_cmd),
    .act_cmd(act_cmd), .irq_cmd(irq_cmd), .flag_events(flag_ev),
    .bus_activity(bus_act), .activity_irq_raised(irq_raised));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Cycle ceiling against hangs; also counts token FIFO advance pulses.
  always @(posedge pclk) begin
    cycles++;
    if (fifo_adv === 1'b1) n_adv++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Word compare; case inequality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  // Only the bench cycle ceiling ends a wait for pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  function automatic logic [31:0] lines();
    return {25'h0, dpu, dmu, dpd, dmd, vbon, vchg, vdis};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(A_CON, 32'h00000000);
    rd(A_PWR, 32'h00000000);
    rd(A_IRQ, 32'h00000000);
    rd(8'h10, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    chk({31'h0, clk_gate}, 32'h00000001);
  endtask

  // Read-only power bits ignore writes; suspend gates the clock.
  task automatic t_power();
    apb(1'b1, A_PWR, 32'hFFFFFFFF);
    rd(A_PWR, 32'h0000001B);
    cyc(2);
    chk({29'h0, clk_gate, xlp, pins}, 32'h00000007);
    apb(1'b1, A_PWR, 32'h00000011);
    cyc(2);
    chk({29'h0, clk_gate, xlp, pins}, 32'h00000001);
  endtask

  // Software and hardware ownership of the pull enables.
  task automatic t_line();
    apb(1'b1, A_CON, 32'hFFFFFFFF);
    rd(A_CON, 32'h000000FF);
    chk({31'h0, err}, 32'h00000000);
    apb(1'b1, 8'h10, 32'h00000000);
    rd(A_CON, 32'h000000FF);
    rd(8'h10, 32'h00000000);
    cyc(2);
    chk(lines(), 32'h0000007F);
    hw_pull <= 4'h9;
    rd(8'h0C, 32'h00000009);
    apb(1'b1, A_CON, 32'h0000000A);
    cyc(2);
    chk(lines(), 32'h0000004E);
    apb(1'b1, A_CON, 32'h00000054);
    cyc(2);
    chk(lines(), 32'h00000028);
  endtask

  // Activity pending and the sleep guard, with the guard on then off.
  task automatic t_activity();
    act_cmd <= 1'b1;
    cyc(3);
    chk({31'h0, slp}, 32'h00000001);
    rd(A_PWR, 32'h00000099);
    act_cmd <= 1'b0;
    cyc(3);
    chk({31'h0, slp}, 32'h00000001);
    irq_cmd <= 1'b1;
    cyc(1);
    irq_cmd <= 1'b0;
    rd(A_PWR, 32'h00000019);
    chk({31'h0, slp}, 32'h00000000);
    apb(1'b1, A_PWR, 32'h00000001);
    act_cmd <= 1'b1;
    cyc(3);
    chk({31'h0, slp}, 32'h00000000);
    act_cmd <= 1'b0;
    irq_cmd <= 1'b1;
    cyc(1);
    irq_cmd <= 1'b0;
  endtask

  // Flag set, ignored writes, one-to-clear and the error summary.
  task automatic t_flags();
    ev_cmd <= 8'hFF;
    cyc(1);
    ev_cmd <= 8'h00;
    rd(A_IRQ, 32'h000000FD);
    apb(1'b1, A_IRQ, 32'h00000000);
    apb(1'b1, A_IRQ, 32'h00000002);
    rd(A_IRQ, 32'h000000FD);
    apb(1'b1, A_IRQ, 32'h00000008);
    rd(A_IRQ, 32'h000000F5);
    chk(32'(n_adv), 32'h00000001);
    err_cond <= 8'h04;
    rd(A_IRQ, 32'h000000F5);
    err_en <= 8'h04;
    cyc(3);
    rd(A_IRQ, 32'h000000F7);
    apb(1'b1, A_IRQ, 32'hFFFFFFFF);
    rd(A_IRQ, 32'h00000002);
    err_en <= 8'h00;
    cyc(3);
    rd(A_IRQ, 32'h00000000);
  endtask

  // Switch-off holds outputs idle and stays busy for the settle time.
  task automatic t_off();
    apb(1'b1, A_CON, 32'h000000FF);
    apb(1'b1, A_PWR, 32'h00000000);
    rd(A_PWR, 32'h00000008);
    chk(lines(), 32'h00000000);
    chk({30'h0, clk_gate, pins}, 32'h00000002);
    cyc(UOPC_SHUTDOWN_CYC + 4);
    rd(A_PWR, 32'h00000000);
  endtask

  // A reset in mid-run returns the control register, line outputs and clock gate to their idle values.
  task automatic t_midreset();
    apb(1'b1, A_CON, 32'h000000FF);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rd(A_CON, 32'h00000000);
    chk(lines(), 32'h00000000);
    chk({31'h0, clk_gate}, 32'h00000001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    hw_pull = 4'h0;
    ev_cmd = 8'h00;
    err_cond = 8'h00;
    err_en = 8'h00;
    act_cmd = 1'b0;
    irq_cmd = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power();
    t_line();
    t_activity();
    t_flags();
    t_off();
    t_midreset();
    give_verdict();
  end
endmodule
